// ### core/css_pkg.sv
// shared constants and types for the converter start-up fault supervisor
// assumes a single 125 MHz clock and status read over the serial
// power-management bus
package css_pkg;

    // clock rate, kilohertz, used to turn milliseconds into cycles
    localparam int CLK_KHZ = 125000;

    // soft-start window and auto-restart delay, milliseconds
    localparam int SS_MIN_MS = 2500;
    localparam int SS_MAX_MS = 12000;
    localparam int AUTO_RESTART_MS = 1000;

    // derived cycle counts (min rounds up, max rounds down; exact here)
    localparam logic [30:0] SS_MIN_CYC = 31'(SS_MIN_MS * CLK_KHZ);
    localparam logic [30:0] SS_MAX_CYC = 31'(SS_MAX_MS * CLK_KHZ);
    localparam logic [30:0] RESTART_CYC = 31'(AUTO_RESTART_MS * CLK_KHZ);

    // bus command codes (register offsets)
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7C;

    // field positions
    localparam int SB_VIN_UV_BIT = 3;
    localparam int SW_INPUT_BIT = 13;
    localparam int SI_VIN_OV_BIT = 7;
    localparam int SI_VIN_UV_BIT = 4;

    // reset values
    localparam logic FLAG_RST = 1'b0;
    localparam logic [30:0] TMR_RST = 31'h0000_0000;
    localparam logic [7:0] CMD_RST = 8'h00;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_UV_WAIT = 7'h02,
        ST_OV_WAIT = 7'h04,
        ST_SOFTSTART = 7'h08,
        ST_RUN = 7'h10,
        ST_RESTART = 7'h20,
        ST_SPARE = 7'h40
    } css_st_e;

    // analog comparator results and bias status, all level inputs
    typedef struct packed {
        logic hi_uv_below_hys;   // high side below uv rise minus hyst
        logic hi_above_uv_rise;  // high side above uv rise threshold
        logic hi_above_ov_rise;  // high side above ov rise threshold
        logic hi_below_ov_hys;   // high side below ov rise minus hyst
        logic ss_done;           // low side reached steady state
        logic inrush_oc;         // overcurrent seen by powertrain
        logic hi_bias_ok;        // high side above bias threshold
        logic lo_bias_ok;        // low side above bias threshold
    } css_sense_s;

    // sequencer state
    typedef struct packed {
        css_st_e st;
        logic [30:0] tmr;
        logic en_q;
        logic uv_flag;
        logic ov_flag;
        logic flt_n;
        logic pt_en;
    } css_ctl_s;

    // serial slave states, one-hot
    typedef enum logic [4:0] {
        BS_IDLE = 5'h01,
        BS_ADDR = 5'h02,
        BS_CMD = 5'h04,
        BS_WDAT = 5'h08,
        BS_READ = 5'h10
    } css_bus_e;

    typedef struct packed {
        css_bus_e st;
        logic mack;
        logic scl_q;
        logic sda_q;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic ack;
        logic hi;
        logic oe;
        logic [7:0] cmd;
        logic clr;
    } css_bus_s;

endpackage

// ### core/css_pmbus_slave.sv
// serial power-management bus slave: byte and word reads, send-byte clear
// assumes scl and sda already synchronous to clk and much slower than it;
// no clock stretching, sda is open drain (oe high pulls the line low)
`timescale 1ns/1ns
module css_pmbus_slave (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [6:0] dev_addr,
    input wire logic [15:0] rdata,
    output logic sda_o,
    output logic sda_oe,
    output logic [7:0] cmd,
    output logic clear_faults
);

    css_pkg::css_bus_s q_reg;
    css_pkg::css_bus_s q_next;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] byte_out;

    // line events from the previous sample
    assign rise = scl_i & ~q_reg.scl_q;
    assign fall = ~scl_i & q_reg.scl_q;
    assign start = scl_i & q_reg.scl_q & q_reg.sda_q & ~sda_i;
    assign stop = scl_i & q_reg.scl_q & ~q_reg.sda_q & sda_i;
    // words go out low byte first, as the bus expects
    assign byte_out = q_reg.hi ? rdata[7:0] : rdata[15:8];

    // next-state of the whole slave
    always_comb begin
        q_next = q_reg;
        q_next.scl_q = scl_i;
        q_next.sda_q = sda_i;
        q_next.clr = 1'b0;
        if (start) begin
            q_next.st = css_pkg::BS_ADDR;
            q_next.cnt = 4'h0;
            q_next.ack = 1'b0;
            q_next.mack = 1'b0;
            q_next.oe = 1'b0;
        end else if (stop) begin
            q_next.st = css_pkg::BS_IDLE;
            q_next.ack = 1'b0;
            q_next.mack = 1'b0;
            q_next.oe = 1'b0;
        end else begin
            case (q_reg.st)
                css_pkg::BS_ADDR, css_pkg::BS_CMD, css_pkg::BS_WDAT: begin
                    if (rise && !q_reg.ack) begin
                        q_next.sh = {q_reg.sh[6:0], sda_i};
                        q_next.cnt = q_reg.cnt + 4'h1;
                    end else if (fall && !q_reg.ack && q_reg.cnt == 4'h8) begin
                        q_next.cnt = 4'h0;
                        if (q_reg.st == css_pkg::BS_ADDR &&
                            q_reg.sh[7:1] != dev_addr) begin
                            q_next.st = css_pkg::BS_IDLE;
                        end else begin
                            q_next.ack = 1'b1;
                            q_next.oe = 1'b1;
                            if (q_reg.st == css_pkg::BS_CMD) begin
                                q_next.cmd = q_reg.sh;
                                // send-byte clear acts once the command is acked
                                q_next.clr =
                                    (q_reg.sh == css_pkg::CMD_CLEAR_FAULTS);
                            end
                        end
                    end else if (fall && q_reg.ack) begin
                        q_next.ack = 1'b0;
                        q_next.oe = 1'b0;
                        if (q_reg.st == css_pkg::BS_ADDR && q_reg.sh[0]) begin
                            q_next.st = css_pkg::BS_READ;
                            q_next.hi = 1'b0;
                            q_next.oe = ~rdata[7];
                            q_next.sh = {rdata[6:0], 1'b0};
                            q_next.cnt = 4'h1;
                        end else if (q_reg.st == css_pkg::BS_ADDR) begin
                            q_next.st = css_pkg::BS_CMD;
                        end else begin
                            q_next.st = css_pkg::BS_WDAT;
                        end
                    end
                end
                css_pkg::BS_READ: begin
                    if (!q_reg.mack && fall) begin
                        if (q_reg.cnt == 4'h8) begin
                            q_next.oe = 1'b0;
                            q_next.mack = 1'b1;
                        end else begin
                            q_next.oe = ~q_reg.sh[7];
                            q_next.sh = {q_reg.sh[6:0], 1'b0};
                            q_next.cnt = q_reg.cnt + 4'h1;
                        end
                    end else if (q_reg.mack && rise) begin
                        // a nack from the master ends the read
                        if (sda_i) begin
                            q_next.st = css_pkg::BS_IDLE;
                            q_next.mack = 1'b0;
                        end else begin
                            q_next.ack = 1'b1;
                        end
                    end else if (q_reg.mack && q_reg.ack && fall) begin
                        q_next.mack = 1'b0;
                        q_next.ack = 1'b0;
                        q_next.hi = ~q_reg.hi;
                        q_next.oe = ~byte_out[7];
                        q_next.sh = {byte_out[6:0], 1'b0};
                        q_next.cnt = 4'h1;
                    end
                end
                default: begin
                    q_next.oe = 1'b0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q_reg <= '{st: css_pkg::BS_IDLE, mack: 1'b0, scl_q: 1'b1,
                       sda_q: 1'b1, sh: 8'h00, cnt: 4'h0, ack: 1'b0,
                       hi: 1'b0, oe: 1'b0, cmd: css_pkg::CMD_RST,
                       clr: 1'b0};
        end else begin
            q_reg <= q_next;
        end
    end

    assign sda_o = 1'b0; // open drain: only ever pulls low
    assign sda_oe = q_reg.oe;
    assign cmd = q_reg.cmd;
    assign clear_faults = q_reg.clr;

endmodule

// ### core/css_supervisor.sv
// converter start-up and high-side fault supervisor with status readout
// assumes comparator levels synchronous to clk and bus lines already
// synchronous; rst is also asserted on loss of bias
`timescale 1ns/1ns
module css_supervisor #(
    parameter logic [30:0] SS_MIN_CYC = css_pkg::SS_MIN_CYC,
    parameter logic [30:0] SS_MAX_CYC = css_pkg::SS_MAX_CYC,
    parameter logic [30:0] RESTART_CYC = css_pkg::RESTART_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire css_pkg::css_sense_s sense,
    input wire logic [6:0] dev_addr,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic fault_indicator_n,
    output logic powertrain_en
);

    css_pkg::css_ctl_s q_reg;
    css_pkg::css_ctl_s q_next;
    logic [7:0] bus_cmd;
    logic clear_faults;
    logic [15:0] rd_word;
    logic bias_lost;

    // status read mux, shared by every read command
    function automatic logic [15:0] reg_read(input logic [7:0] c,
                                             input logic uv,
                                             input logic ov);
        logic [15:0] w;
        w = 16'h0000;
        case (c)
            css_pkg::CMD_STATUS_BYTE: begin
                w[css_pkg::SB_VIN_UV_BIT] = uv;
            end
            css_pkg::CMD_STATUS_WORD: begin
                w[css_pkg::SB_VIN_UV_BIT] = uv;
                w[css_pkg::SW_INPUT_BIT] = uv | ov;
            end
            css_pkg::CMD_INPUT_STATUS: begin
                w[css_pkg::SI_VIN_UV_BIT] = uv;
                w[css_pkg::SI_VIN_OV_BIT] = ov;
            end
            default: begin
                w = 16'h0000; // unmapped commands read as zero
            end
        endcase
        return w;
    endfunction

    assign rd_word = reg_read(bus_cmd, q_reg.uv_flag, q_reg.ov_flag);
    assign bias_lost = ~sense.hi_bias_ok | ~sense.lo_bias_ok;

    // sequencer and flag next-state
    always_comb begin
        q_next = q_reg;
        q_next.en_q = enable;
        q_next.tmr = q_reg.tmr + 31'h1;
        case (q_reg.st)
            css_pkg::ST_IDLE: begin
                q_next.tmr = css_pkg::TMR_RST;
                // checks happen only on the enable edge
                if (enable && !q_reg.en_q) begin
                    if (sense.hi_uv_below_hys) begin
                        q_next.st = css_pkg::ST_UV_WAIT;
                    end else if (sense.hi_above_ov_rise) begin
                        q_next.st = css_pkg::ST_OV_WAIT;
                    end else begin
                        q_next.st = css_pkg::ST_SOFTSTART;
                    end
                end
            end
            css_pkg::ST_UV_WAIT: begin
                q_next.tmr = css_pkg::TMR_RST;
                if (sense.hi_above_uv_rise) begin
                    q_next.st = css_pkg::ST_SOFTSTART;
                end
            end
            css_pkg::ST_OV_WAIT: begin
                q_next.tmr = css_pkg::TMR_RST;
                if (sense.hi_below_ov_hys) begin
                    q_next.st = css_pkg::ST_SOFTSTART;
                end
            end
            css_pkg::ST_SOFTSTART: begin
                if (sense.inrush_oc) begin
                    q_next.st = css_pkg::ST_RESTART;
                    q_next.tmr = css_pkg::TMR_RST;
                end else if (sense.ss_done && q_reg.tmr >= SS_MIN_CYC) begin
                    q_next.st = css_pkg::ST_RUN;
                end else if (q_reg.tmr >= SS_MAX_CYC) begin
                    // timed-out ramp retries forever, never giving up
                    q_next.st = css_pkg::ST_RESTART;
                    q_next.tmr = css_pkg::TMR_RST;
                end
            end
            css_pkg::ST_RUN: begin
                q_next.tmr = css_pkg::TMR_RST;
            end
            css_pkg::ST_RESTART: begin
                if (q_reg.tmr >= RESTART_CYC) begin
                    q_next.st = css_pkg::ST_SOFTSTART;
                    q_next.tmr = css_pkg::TMR_RST;
                end
            end
            default: begin
                q_next.st = css_pkg::ST_IDLE;
                q_next.tmr = css_pkg::TMR_RST;
            end
        endcase
        // enable low wins over everything and cancels pending starts
        if (!enable) begin
            q_next.st = css_pkg::ST_IDLE;
            q_next.tmr = css_pkg::TMR_RST;
        end
        // sticky flags: a set in the clear cycle wins; bias loss wipes them
        if (clear_faults) begin
            q_next.uv_flag = 1'b0;
            q_next.ov_flag = 1'b0;
        end
        if (q_next.st == css_pkg::ST_UV_WAIT) begin
            q_next.uv_flag = 1'b1;
        end
        if (q_next.st == css_pkg::ST_OV_WAIT) begin
            q_next.ov_flag = 1'b1;
        end
        if (bias_lost) begin
            q_next.uv_flag = css_pkg::FLAG_RST;
            q_next.ov_flag = css_pkg::FLAG_RST;
        end
        // indicator high only once soft-start has finished
        q_next.flt_n = (q_next.st == css_pkg::ST_RUN);
        q_next.pt_en = (q_next.st == css_pkg::ST_SOFTSTART) ||
                       (q_next.st == css_pkg::ST_RUN);
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q_reg <= '{st: css_pkg::ST_IDLE, tmr: css_pkg::TMR_RST,
                       en_q: 1'b0, uv_flag: css_pkg::FLAG_RST,
                       ov_flag: css_pkg::FLAG_RST, flt_n: 1'b0,
                       pt_en: 1'b0};
        end else begin
            q_reg <= q_next;
        end
    end

    assign fault_indicator_n = q_reg.flt_n;
    assign powertrain_en = q_reg.pt_en;

    // status readout over the serial bus
    css_pmbus_slave u_bus (
        .clk(clk),
        .rst(rst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .dev_addr(dev_addr),
        .rdata(rd_word),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .cmd(bus_cmd),
        .clear_faults(clear_faults)
    );

    // checks on the sequencer
    // the indicator may only rise out of a soft-start that reached steady
    // state, so a load switched on by it never meets a dead powertrain
    chk_flt_run: assert property (@(posedge clk) disable iff (rst)
        $rose(fault_indicator_n) |->
        $past(q_reg.st == css_pkg::ST_SOFTSTART && sense.ss_done))
        else $error("fault indicator rose outside soft-start completion");

    chk_uv_block: assert property (@(posedge clk) disable iff (rst)
        (q_reg.st == css_pkg::ST_IDLE && enable && !q_reg.en_q &&
         sense.hi_uv_below_hys)
        |=> (q_reg.st == css_pkg::ST_UV_WAIT) && !powertrain_en)
        else $error("undervoltage did not block start");

    // lockout still standing: the set beats any host clear
    chk_uv_flags: assert property (@(posedge clk) disable iff (rst)
        (q_reg.st == css_pkg::ST_UV_WAIT && enable &&
         !sense.hi_above_uv_rise && !bias_lost) |=> q_reg.uv_flag)
        else $error("undervoltage flag not set");

    chk_ov_block: assert property (@(posedge clk) disable iff (rst)
        (q_reg.st == css_pkg::ST_IDLE && enable && !q_reg.en_q &&
         !bias_lost && !sense.hi_uv_below_hys && sense.hi_above_ov_rise)
        |=> (q_reg.st == css_pkg::ST_OV_WAIT) && !powertrain_en &&
            q_reg.ov_flag)
        else $error("overvoltage did not block start");

    chk_uv_resume: assert property (@(posedge clk) disable iff (rst)
        (q_reg.st == css_pkg::ST_UV_WAIT && enable && sense.hi_above_uv_rise)
        |=> q_reg.st == css_pkg::ST_SOFTSTART && powertrain_en)
        else $error("no restart after undervoltage recovery");

    chk_ov_resume: assert property (@(posedge clk) disable iff (rst)
        (q_reg.st == css_pkg::ST_OV_WAIT && enable && sense.hi_below_ov_hys)
        |=> q_reg.st == css_pkg::ST_SOFTSTART)
        else $error("no restart after overvoltage recovery");

    chk_lockout_low: assert property (@(posedge clk) disable iff (rst)
        (q_reg.st == css_pkg::ST_UV_WAIT || q_reg.st == css_pkg::ST_OV_WAIT)
        |-> !fault_indicator_n)
        else $error("fault indicator high during lockout");

    chk_inrush_stop: assert property (@(posedge clk) disable iff (rst)
        (q_reg.st == css_pkg::ST_SOFTSTART && enable && sense.inrush_oc)
        |=> q_reg.st == css_pkg::ST_RESTART && !powertrain_en &&
            q_reg.tmr == 31'h0)
        else $error("inrush did not stop soft-start");

    chk_ss_early: assert property (@(posedge clk) disable iff (rst)
        $rose(q_reg.st == css_pkg::ST_RUN) |-> $past(q_reg.tmr) >= SS_MIN_CYC)
        else $error("soft-start finished too early");

    chk_en_off: assert property (@(posedge clk) disable iff (rst)
        !enable |=> q_reg.st == css_pkg::ST_IDLE && !powertrain_en)
        else $error("enable low did not stop sequencing");

    chk_flag_hold: assert property (@(posedge clk) disable iff (rst)
        (q_reg.uv_flag && !clear_faults && !bias_lost) |=> q_reg.uv_flag)
        else $error("undervoltage flag dropped on its own");

    chk_retry_loop: assert property (@(posedge clk) disable iff (rst)
        (q_reg.st == css_pkg::ST_RESTART && enable &&
         q_reg.tmr >= RESTART_CYC) |=>
        q_reg.st == css_pkg::ST_SOFTSTART && powertrain_en)
        else $error("no new attempt after the restart delay");

    chk_ss_timeout: assert property (@(posedge clk) disable iff (rst)
        (q_reg.st == css_pkg::ST_SOFTSTART && enable && !sense.inrush_oc &&
         !sense.ss_done && q_reg.tmr >= SS_MAX_CYC) |=>
        q_reg.st == css_pkg::ST_RESTART && !powertrain_en)
        else $error("soft-start ran past its longest window");

    cov_run: cover property (@(posedge clk) disable iff (rst)
        $rose(q_reg.st == css_pkg::ST_RUN));
    cov_retry: cover property (@(posedge clk) disable iff (rst)
        q_reg.st == css_pkg::ST_RESTART ##1 q_reg.st == css_pkg::ST_SOFTSTART);
    cov_uv_start: cover property (@(posedge clk) disable iff (rst)
        q_reg.st == css_pkg::ST_UV_WAIT ##1 q_reg.st == css_pkg::ST_SOFTSTART);
    cov_clear: cover property (@(posedge clk) disable iff (rst)
        q_reg.uv_flag && clear_faults);

endmodule

// ### verification/css_host_model.sv
// bus host model: drives scl, pulls sda low, reads status words
// assumes the bench resolves the open-drain sda wire with a pull-up
`timescale 1ns/1ns
module css_host_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // one bus phase, kept long because the slave samples once per clk
    task automatic ph();
        repeat (4) @(posedge clk);
    endtask

    // drive a bit, clock it, take the line level while scl is high
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        ph();
        scl <= 1'b1;
        ph();
        r = sda;
        scl <= 1'b0;
        ph();
    endtask

    // eight data bits then the acknowledge bit, msb first
    task automatic xfer(input logic [8:0] b, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
    endtask

    // start or repeated start: sda falls while scl is high
    task automatic start();
        sda_low <= 1'b0;
        ph();
        scl <= 1'b1;
        ph();
        sda_low <= 1'b1;
        ph();
        scl <= 1'b0;
        ph();
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        ph();
        scl <= 1'b1;
        ph();
        sda_low <= 1'b0;
        ph();
    endtask

    // command write, repeated start, low byte acked, high byte nacked
    task automatic read(input logic [6:0] a, input logic [7:0] c,
                        output logic [15:0] d);
        logic [8:0] r;
        logic [8:0] lo;
        start();
        xfer({a, 2'b01}, r);
        xfer({c, 1'b1}, r);
        start();
        xfer({a, 2'b11}, r);
        xfer(9'h1FE, lo);
        xfer(9'h1FF, r);
        stop();
        d = {r[8:1], lo[8:1]};
    endtask

    // send byte: command alone, used for the flag clear
    task automatic send(input logic [6:0] a, input logic [7:0] c);
        logic [8:0] r;
        start();
        xfer({a, 2'b01}, r);
        xfer({c, 1'b1}, r);
        stop();
    endtask
endmodule

// ### verification/css_supervisor_tb.sv
// self-checking bench for the start-up fault supervisor
// assumes shortened soft-start and restart counts and the host model
`timescale 1ns/1ns
module css_supervisor_tb;
    localparam logic [30:0] SMIN = 31'h14;
    localparam logic [30:0] SMAX = 31'h3C;
    localparam logic [30:0] RCYC = 31'h0A;
    logic clk, rst, enable, scl, sda_low, sda_o, sda_oe, fault_n, pt_en;
    logic [6:0] addr;
    logic [15:0] lfsr_q, d;
    css_pkg::css_sense_s sense;
    int errors, n_compared, cyc, n;
    wire sda = !(sda_low | sda_oe); // open drain, pulled up

    css_supervisor #(.SS_MIN_CYC(SMIN), .SS_MAX_CYC(SMAX),
        .RESTART_CYC(RCYC)) dut (.clk(clk), .rst(rst), .enable(enable),
        .sense(sense), .dev_addr(addr), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .fault_indicator_n(fault_n),
        .powertrain_en(pt_en));
    css_host_model host (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(sda_low));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // expected read data from the flag values
    function automatic logic [15:0] exp_rd(input logic [7:0] c,
                                           input logic uv, input logic ov);
        case (c)
            8'h78: return {8'h00, 4'h0, uv, 3'h0};
            8'h79: return {2'h0, uv | ov, 9'h000, uv, 3'h0};
            8'h7C: return {8'h00, ov, 2'h0, uv, 4'h0};
            default: return 16'h0000;
        endcase
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask

    // bounded wait for the powertrain enable to reach v
    task automatic wait_pt(input logic v, output int k);
        k = 0;
        while (pt_en !== v && k < 300) begin
            @(negedge clk);
            k++;
        end
    endtask

    // byte registers keep only their low byte; 7Ah is unmapped
    task automatic flags(input logic uv, input logic ov);
        logic [7:0] c [4] = '{8'h78, 8'h79, 8'h7C, 8'h7A};
        foreach (c[i]) begin
            host.read(addr, c[i], d);
            if (c[i] inside {8'h78, 8'h7C}) d[15:8] = 8'h00;
            chk(d, exp_rd(c[i], uv, ov));
        end
    endtask

    task automatic outs(input logic [1:0] exp);
        chk({13'h0, sda_o, fault_n, pt_en}, {14'h0, exp}); // sda_o stays 0
    endtask

    // the system's load switch follows fault_n; it must never load a
    // converter whose powertrain is not switching
    always @(negedge clk) begin
        if (!rst) chk({15'h0, fault_n & !pt_en}, 16'h0000);
    end

    // hang guard: far above the roughly 12750 cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        rst = 1'b1;
        enable = 1'b0;
        lfsr_q = 16'h73B3;
        addr = {1'b1, lfsr_q[5:0]};
        sense = css_pkg::css_sense_s'(8'h53);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        outs(2'b00);
        // undervoltage at enable rise blocks start
        @(posedge clk);
        sense.hi_uv_below_hys <= 1'b1;
        sense.hi_above_uv_rise <= 1'b0;
        enable <= 1'b1;
        tick(3);
        outs(2'b00);
        flags(1'b1, 1'b0);
        lfsr_q = lfsr(lfsr_q);
        tick(lfsr_q[2:0]);
        @(posedge clk);
        sense.hi_uv_below_hys <= 1'b0;
        sense.hi_above_uv_rise <= 1'b1;
        sense.ss_done <= 1'b1;
        wait_pt(1'b1, n);
        chk(16'(n < 4), 16'h0001);
        // early steady state must not end soft-start before SMIN
        tick(15);
        outs(2'b01);
        tick(10);
        outs(2'b11);
        flags(1'b1, 1'b0);
        host.read(addr ^ 7'h01, 8'h79, d);
        chk(d, 16'hFFFF);
        host.send(addr, 8'h03);
        flags(1'b0, 1'b0);
        @(posedge clk);
        enable <= 1'b0;
        tick(3);
        outs(2'b00);
        // overvoltage at enable rise, then enable drop cancels the wait
        @(posedge clk);
        sense.hi_above_ov_rise <= 1'b1;
        sense.hi_below_ov_hys <= 1'b0;
        sense.ss_done <= 1'b0;
        enable <= 1'b1;
        tick(3);
        outs(2'b00);
        flags(1'b0, 1'b1);
        @(posedge clk);
        enable <= 1'b0;
        sense.hi_above_ov_rise <= 1'b0;
        sense.hi_below_ov_hys <= 1'b1;
        tick(20);
        outs(2'b00);
        @(posedge clk);
        sense.hi_above_ov_rise <= 1'b1;
        sense.hi_below_ov_hys <= 1'b0;
        enable <= 1'b1;
        tick(3);
        outs(2'b00);
        @(posedge clk);
        sense.hi_above_ov_rise <= 1'b0;
        sense.hi_below_ov_hys <= 1'b1;
        wait_pt(1'b1, n);
        chk(16'(n < 4), 16'h0001);
        // inrush overcurrent stops start, retry after the delay
        @(posedge clk);
        sense.inrush_oc <= 1'b1;
        wait_pt(1'b0, n);
        chk(16'(n < 4), 16'h0001);
        @(posedge clk);
        sense.inrush_oc <= 1'b0;
        wait_pt(1'b1, n);
        chk(16'(n >= RCYC - 2 && n <= RCYC + 3), 16'h0001);
        // no steady state: soft-start times out and retries, two rounds checked
        for (int k = 0; k < 2; k++) begin
            wait_pt(1'b0, n);
            chk(16'(n >= SMAX - 2 && n <= SMAX + 3), 16'h0001);
            outs(2'b00);
            wait_pt(1'b1, n);
            chk(16'(n <= RCYC + 3), 16'h0001);
        end
        // a short bias loss on either side wipes the sticky flags
        @(posedge clk);
        lfsr_q = lfsr(lfsr_q);
        if (lfsr_q[0]) sense.hi_bias_ok <= 1'b0;
        else sense.lo_bias_ok <= 1'b0;
        tick(2);
        @(posedge clk);
        sense.hi_bias_ok <= 1'b1;
        sense.lo_bias_ok <= 1'b1;
        flags(1'b0, 1'b0);
        end_of_test();
    end
endmodule
